// *** core/rsv_mgr.sv ***
// Purpose: reservation manager of the disk controller command interpreter
// Assumes: one command per cycle, all inputs but the asynchronous reset synchronous to clk
// Notes: answer appears one cycle after the command is taken
`timescale 1ns/1ns

// How it works
// R1 - clear extent flag reserves whole unit
// R2 - unit reservation ends by release or reset
// R3 - owner may reserve its unit again
// R4 - whole-unit reserve ignores id and length
// R5 - held unit or extent gives conflict status
// R6 - foreign read or write on held unit conflicts
// R7 - request sense after conflict shows no sense
// R8 - store identifier with each extent reservation
// R9 - more than one extent gives 21h
// R10 - bad extent address gives 21h
// R11 - extent request on held unit: illegal request
// R12 - conflict-free extent granted until release/reset
// R13 - extent list length must be 8 or 0
// R14 - start bytes 04-07, count 01-03, zero=end
// R15 - reservation type from descriptor low bits
// R16 - read exclusive blocks foreign reads
// R17 - write exclusive blocks foreign writes
// R18 - exclusive access blocks everything foreign
// R19 - read shared blocks all writes
// R20 - relative address needs prior linked block
// R21 - conflicting access performs nothing, conflict status
// R22 - format on unit with any extent or a foreign whole-unit reservation gives conflict
// R23 - release ends all or matching id
// R24 - records per unit, checked combinationally
module rsv_mgr
  import rsv_pkg::*;
#(
  parameter int NREC = NREC_DEF
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire rsv_op_e cmd_op,
  input wire logic [ID_W-1:0] cmd_init,
  input wire logic [LUN_W-1:0] cmd_lun,
  input wire logic cmd_extent,
  input wire logic [7:0] cmd_res_id,
  input wire logic [15:0] cmd_list_len,
  input wire logic [LBA_W-1:0] cmd_lba,
  input wire logic [CNT_W-1:0] cmd_blocks,
  input wire logic [1:0] desc_type,
  input wire logic desc_rel_addr,
  input wire logic [CNT_W-1:0] desc_blocks,
  input wire logic [LBA_W-1:0] desc_lba,
  input wire logic [LBA_W-1:0] unit_blocks,
  input wire logic link_addr_valid,
  input wire logic [LBA_W-1:0] link_addr,
  input wire logic bus_dev_reset,
  output logic rsp_valid,
  output logic [7:0] rsp_status,
  output logic [7:0] rsp_code,
  output logic [NUM_LUN-1:0] unit_held
);

  localparam int IDX_W = (NREC > 1) ? $clog2(NREC) : 1;

  // last block of a run starting at lo, n blocks long
  function automatic logic [33:0] last_blk(input logic [33:0] lo, input logic [CNT_W-1:0] n);
    return lo + {10'h000, n} - 34'h000000001;
  endfunction : last_blk

  // reservation table and per-initiator sense
  rsv_rec_s rec_q [NREC];
  rsv_rec_s rec_d [NREC];
  logic [7:0] sense_q [NUM_INIT];
  logic [7:0] sense_d [NUM_INIT];

  logic rsp_valid_q;
  logic rsp_valid_d;
  logic [7:0] rsp_status_q;
  logic [7:0] rsp_status_d;
  logic [7:0] rsp_code_q;
  logic [7:0] rsp_code_d;
  logic [NUM_LUN-1:0] held_q;
  logic [NUM_LUN-1:0] held_d;

  // checker results
  logic [NREC-1:0] hit;
  logic [NREC-1:0] own_w;
  logic [NREC-1:0] any_w;
  logic any_conf;
  logic own_whole;
  logic whole_held;

  // extent and access arithmetic
  logic [33:0] ext_start;
  logic [33:0] ext_end;
  logic [33:0] unit_end;
  logic ext_bad;
  logic [33:0] acc_end;
  logic [LBA_W-1:0] acc_hi;
  rsv_type_e ext_type;

  // free slot search
  logic [IDX_W-1:0] free_idx;
  logic free_ok;

  // working values of the command decision
  logic [7:0] st;
  logic [7:0] cd;
  logic grant;
  rsv_rec_s new_rec;

  rsv_req_if req ();

  // R15 type code decode
  assign ext_type = rsv_type_e'(desc_type);

  // R14 extent start and end
  // R20 relative displacement
  assign unit_end = {2'b00, unit_blocks} - 34'h000000001;
  assign ext_start = desc_rel_addr ? ({2'b00, link_addr} + {{2{desc_lba[LBA_W-1]}}, desc_lba})
    : {2'b00, desc_lba};
  assign ext_end = (desc_blocks == '0) ? unit_end : last_blk(ext_start, desc_blocks);

  // R10 address validity
  assign ext_bad = ext_start[33] || (ext_start >= {2'b00, unit_blocks})
    || (ext_end >= {2'b00, unit_blocks});

  // access range, saturated at the top block
  assign acc_end = (cmd_blocks == '0) ? {2'b00, cmd_lba} : last_blk({2'b00, cmd_lba}, cmd_blocks);
  assign acc_hi = (acc_end[33:32] != 2'b00) ? LBA_TOP : acc_end[LBA_W-1:0];

  // request presented to all record checkers
  always_comb begin
    req.kind = CK_NONE;
    req.lun = cmd_lun;
    req.init = cmd_init;
    req.typ = ext_type;
    req.lo = '0;
    req.hi = LBA_TOP;
    if (cmd_valid) begin
      unique case (cmd_op)
        OP_RESERVE: begin
          req.kind = cmd_extent ? CK_EXTENT : CK_WHOLE;
          if (cmd_extent) begin
            req.lo = ext_start[LBA_W-1:0];
            req.hi = ext_end[LBA_W-1:0];
          end
        end
        OP_READ: begin
          req.kind = CK_READ;
          req.lo = cmd_lba;
          req.hi = acc_hi;
        end
        OP_WRITE: begin
          req.kind = CK_WRITE;
          req.lo = cmd_lba;
          req.hi = acc_hi;
        end
        OP_FORMAT: req.kind = CK_FORMAT;
        default: req.kind = CK_NONE;
      endcase
    end
  end

  // R24 one checker per record
  for (genvar g = 0; g < NREC; g++) begin : g_chk
    rsv_rec_chk u_chk (
      .rq(req),
      .rec(rec_q[g]),
      .conflict(hit[g]),
      .own_whole(own_w[g]),
      .any_whole(any_w[g])
    );
  end

  assign any_conf = |hit;
  assign own_whole = |own_w;
  assign whole_held = |any_w;

  // lowest free record slot
  always_comb begin
    free_idx = '0;
    free_ok = 1'b0;
    for (int i = NREC - 1; i >= 0; i--) begin
      if (!rec_q[i].valid) begin
        free_idx = IDX_W'(i);
        free_ok = 1'b1;
      end
    end
  end

  // command decision and table update
  always_comb begin
    rec_d = rec_q;
    sense_d = sense_q;
    rsp_valid_d = 1'b0;
    rsp_status_d = rsp_status_q;
    rsp_code_d = rsp_code_q;
    st = ST_GOOD;
    cd = ERR_NO_SENSE;
    grant = 1'b0;
    new_rec = REC_EMPTY;
    held_d = '0;
    if (cmd_valid) begin
      unique case (cmd_op)
        OP_RESERVE: begin
          if (!cmd_extent) begin
            // R4 id and length unused here
            // R5 unit or extent already held
            if (any_conf) begin
              st = ST_CONFLICT;
            // R3 repeat by owner is good
            end else if (!own_whole) begin
              // R1 whole unit reservation
              new_rec = '{valid: 1'b1, lun: cmd_lun, init: cmd_init, whole: 1'b1,
                typ: TY_EXCL, id: 8'h00, lo: '0, hi: LBA_TOP};
              grant = 1'b1;
            end
          // R9 one extent only
          end else if (cmd_list_len > EXT_LEN_ONE) begin
            st = ST_CHECK;
            cd = ERR_ILL_BLOCK;
          // R13 length 8 or 0
          end else if (cmd_list_len != EXT_LEN_NONE && cmd_list_len != EXT_LEN_ONE) begin
            st = ST_CHECK;
            cd = ERR_BAD_ARG;
          end else if (cmd_list_len == EXT_LEN_NONE) begin
            st = ST_GOOD;
          // R20 no linked block yet
          end else if (desc_rel_addr && !link_addr_valid) begin
            st = ST_CHECK;
            cd = ERR_BAD_ARG;
          // R10 address out of unit
          end else if (ext_bad) begin
            st = ST_CHECK;
            cd = ERR_ILL_BLOCK;
          // R11 unit already held
          end else if (whole_held) begin
            st = ST_CHECK;
            cd = ERR_ILL_REQ;
          end else if (any_conf) begin
            st = ST_CONFLICT;
          end else begin
            // R12 extent granted
            // R8 identifier kept
            new_rec = '{valid: 1'b1, lun: cmd_lun, init: cmd_init, whole: 1'b0,
              typ: ext_type, id: cmd_res_id, lo: ext_start[LBA_W-1:0], hi: ext_end[LBA_W-1:0]};
            grant = 1'b1;
          end
          // table full reads as a clash with held records
          if (grant && !free_ok) begin
            grant = 1'b0;
            st = ST_CONFLICT;
          end
          if (grant) begin
            rec_d[free_idx] = new_rec;
          end
        end
        OP_RELEASE: begin
          // R23 release all or matching id
          // R2 unit released by owner
          for (int i = 0; i < NREC; i++) begin
            if (rec_q[i].valid && rec_q[i].lun == cmd_lun && rec_q[i].init == cmd_init
                && (!cmd_extent || (!rec_q[i].whole && rec_q[i].id == cmd_res_id))) begin
              rec_d[i].valid = 1'b0;
            end
          end
        end
        OP_READ, OP_WRITE, OP_FORMAT: begin
          // R6 R21 R22 reject whole command
          if (any_conf) begin
            st = ST_CONFLICT;
          end
        end
        OP_SENSE: begin
          cd = sense_q[cmd_init];
        end
        default: st = ST_GOOD;
      endcase
      // R7 sense after conflict is none
      if (cmd_op != OP_SENSE) begin
        sense_d[cmd_init] = (st == ST_CHECK) ? cd : ERR_NO_SENSE;
      end else begin
        sense_d[cmd_init] = ERR_NO_SENSE;
      end
      rsp_valid_d = 1'b1;
      rsp_status_d = st;
      rsp_code_d = cd;
    end
    // R2 R12 bus device reset clears all
    if (bus_dev_reset) begin
      for (int i = 0; i < NREC; i++) begin
        rec_d[i].valid = 1'b0;
      end
    end
    // units holding any record
    for (int i = 0; i < NREC; i++) begin
      if (rec_d[i].valid) begin
        held_d[rec_d[i].lun] = 1'b1;
      end
    end
  end

  // state registers, hard reset clears every reservation
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NREC; i++) begin
        rec_q[i] <= REC_EMPTY;
      end
      for (int i = 0; i < NUM_INIT; i++) begin
        sense_q[i] <= ERR_NO_SENSE;
      end
      rsp_valid_q <= 1'b0;
      rsp_status_q <= ST_GOOD;
      rsp_code_q <= ERR_NO_SENSE;
      held_q <= '0;
    end else begin
      rec_q <= rec_d;
      sense_q <= sense_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_status_q <= rsp_status_d;
      rsp_code_q <= rsp_code_d;
      held_q <= held_d;
    end
  end

  // outputs straight from flops
  assign rsp_valid = rsp_valid_q;
  assign rsp_status = rsp_status_q;
  assign rsp_code = rsp_code_q;
  assign unit_held = held_q;

endmodule : rsv_mgr

// *** pkg/rsv_pkg.sv ***
// Purpose: shared constants, types and helpers of the reservation manager
// Assumes: eight bus initiators, eight logical units, 32-bit block addresses
// Notes: status bytes follow the usual bus status codes
package rsv_pkg;

  localparam int LBA_W = 32;
  localparam int CNT_W = 24;
  localparam int ID_W = 3;
  localparam int LUN_W = 3;
  localparam int NUM_INIT = 8;
  localparam int NUM_LUN = 8;
  localparam int NREC_DEF = 8;

  // extent list lengths the device accepts
  localparam logic [15:0] EXT_LEN_ONE = 16'h0008;
  localparam logic [15:0] EXT_LEN_NONE = 16'h0000;

  // status bytes
  localparam logic [7:0] ST_GOOD = 8'h00;
  localparam logic [7:0] ST_CHECK = 8'h02;
  localparam logic [7:0] ST_CONFLICT = 8'h18;

  // error codes kept for request sense
  localparam logic [7:0] ERR_NO_SENSE = 8'h00;
  localparam logic [7:0] ERR_ILL_REQ = 8'h20;
  localparam logic [7:0] ERR_ILL_BLOCK = 8'h21;
  localparam logic [7:0] ERR_BAD_ARG = 8'h24;

  localparam logic [LBA_W-1:0] LBA_TOP = {LBA_W{1'b1}};

  typedef enum logic [2:0] {
    OP_RESERVE = 3'h0,
    OP_RELEASE = 3'h1,
    OP_READ = 3'h2,
    OP_WRITE = 3'h3,
    OP_FORMAT = 3'h4,
    OP_SENSE = 3'h5
  } rsv_op_e;

  typedef enum logic [1:0] {
    TY_RD_SHARED = 2'h0,
    TY_WR_EXCL = 2'h1,
    TY_RD_EXCL = 2'h2,
    TY_EXCL = 2'h3
  } rsv_type_e;

  typedef enum logic [2:0] {
    CK_NONE = 3'h0,
    CK_WHOLE = 3'h1,
    CK_EXTENT = 3'h2,
    CK_READ = 3'h3,
    CK_WRITE = 3'h4,
    CK_FORMAT = 3'h5
  } rsv_kind_e;

  typedef struct packed {
    logic valid;
    logic [LUN_W-1:0] lun;
    logic [ID_W-1:0] init;
    logic whole;
    rsv_type_e typ;
    logic [7:0] id;
    logic [LBA_W-1:0] lo;
    logic [LBA_W-1:0] hi;
  } rsv_rec_s;

  localparam rsv_rec_s REC_EMPTY = '0;

  // overlapping extents clash unless shared+shared or read-excl+write-excl
  function automatic logic types_clash(input rsv_type_e a, input rsv_type_e b);
    logic shared_pair;
    logic split_pair;
    shared_pair = (a == TY_RD_SHARED) && (b == TY_RD_SHARED);
    split_pair = ((a == TY_RD_EXCL) && (b == TY_WR_EXCL)) || ((a == TY_WR_EXCL) && (b == TY_RD_EXCL));
    return !(shared_pair || split_pair);
  endfunction : types_clash

endpackage : rsv_pkg

// *** pkg/rsv_req_if.sv ***
// Purpose: carries the request under check to every record checker
// Assumes: driven combinationally by the manager
// Notes: kind CK_NONE means no check is wanted
`timescale 1ns/1ns
interface rsv_req_if;
  import rsv_pkg::*;
  rsv_kind_e kind;
  logic [LUN_W-1:0] lun;
  logic [ID_W-1:0] init;
  rsv_type_e typ;
  logic [LBA_W-1:0] lo;
  logic [LBA_W-1:0] hi;
  modport src (output kind, output lun, output init, output typ, output lo, output hi);
  modport chk (input kind, input lun, input init, input typ, input lo, input hi);
endinterface : rsv_req_if

// *** core/rsv_rec_chk.sv ***
// Purpose: judges one reservation record against the request under check
// Assumes: whole-unit records span the full address range
// Notes: purely combinational
`timescale 1ns/1ns
module rsv_rec_chk
  import rsv_pkg::*;
(
  rsv_req_if.chk rq,
  input rsv_rec_s rec,
  output logic conflict,
  output logic own_whole,
  output logic any_whole
);

  logic on_unit;
  logic other;
  logic ovl;

  // record relation to the requester
  assign on_unit = rec.valid && (rec.lun == rq.lun);
  assign other = rec.init != rq.init;
  assign ovl = (rq.lo <= rec.hi) && (rec.lo <= rq.hi);
  assign own_whole = on_unit && rec.whole && !other;
  assign any_whole = on_unit && rec.whole;

  // conflict verdict per kind of check
  always_comb begin
    conflict = 1'b0;
    unique case (rq.kind)
      // R5 held unit clashes
      CK_WHOLE: conflict = on_unit && !(rec.whole && !other);
      // R16 R17 R18 R19 type matrix
      CK_EXTENT: conflict = on_unit && !rec.whole && ovl && types_clash(rec.typ, rq.typ);
      // R6 R16 R18 foreign read blocked
      CK_READ: conflict = on_unit && ovl && other
        && (rec.whole || rec.typ == TY_RD_EXCL || rec.typ == TY_EXCL);
      // R17 R19 writes blocked
      CK_WRITE: conflict = on_unit && ovl
        && ((other && (rec.whole || rec.typ == TY_WR_EXCL || rec.typ == TY_EXCL))
        || (!rec.whole && rec.typ == TY_RD_SHARED));
      // R22 format blocked
      CK_FORMAT: conflict = on_unit && (!rec.whole || other);
      default: conflict = 1'b0;
    endcase
  end

endmodule : rsv_rec_chk

// *** dv/rsv_host.sv ***
// Purpose: model of the bus initiators that issue commands
// Assumes: one command at a time, its answer awaited
// Notes: address lines flip once the strobe drops
`timescale 1ns/1ns
module rsv_host
  import rsv_pkg::*;
(
  input wire logic clk,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_status,
  input wire logic [7:0] rsp_code,
  output logic cmd_valid,
  output rsv_op_e cmd_op,
  output logic [ID_W-1:0] cmd_init,
  output logic cmd_extent,
  output logic [7:0] cmd_res_id,
  output logic [15:0] cmd_list_len,
  output logic [1:0] desc_type,
  output logic [1:0] rel,
  output logic [LBA_W-1:0] lba,
  output logic [CNT_W-1:0] blocks
);
  logic [7:0] st;
  logic [7:0] cd;

  // idle bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_op = OP_SENSE;
    cmd_init = '0;
    cmd_extent = 1'b0;
    cmd_res_id = 8'h00;
    cmd_list_len = 16'h0000;
    desc_type = 2'h0;
    rel = 2'h0;
    lba = '0;
    blocks = '0;
  end

  // one command, held one edge, then wait for the answer
  // caller gives length 8 or 0 unless probing refusal or the ignored length of a whole-unit reserve
  task automatic send(input rsv_op_e op, input int ini, input int ext, input int id, input int len,
    input int ty, input int r, input int a, input int n);
    int i;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_init <= ID_W'(ini);
    cmd_extent <= ext[0];
    cmd_res_id <= 8'(id);
    cmd_list_len <= 16'(len);
    desc_type <= ty[1:0];
    rel <= r[1:0];
    lba <= LBA_W'(a);
    blocks <= CNT_W'(n);
    @(posedge clk);
    cmd_valid <= 1'b0;
    lba <= ~LBA_W'(a);
    st = 8'hxx;
    cd = 8'hxx;
    for (i = 0; i < 4; i++) begin
      #1;
      if (rsp_valid === 1'b1) begin
        st = rsp_status;
        cd = rsp_code;
        break;
      end
      @(posedge clk);
    end
  endtask : send
endmodule : rsv_host

// *** dv/rsv_mgr_asserts.sv ***
// Purpose: port-level checks of the reservation manager
// Assumes: answers one cycle after the command
// Notes: attached by bind below
`timescale 1ns/1ns
module rsv_mgr_asserts
  import rsv_pkg::*;
#(
  parameter int NREC = NREC_DEF
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire rsv_op_e cmd_op,
  input wire logic cmd_extent,
  input wire logic [15:0] cmd_list_len,
  input wire logic desc_rel_addr,
  input wire logic link_addr_valid,
  input wire logic bus_dev_reset,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_status,
  input wire logic [7:0] rsp_code,
  input wire logic [NUM_LUN-1:0] unit_held
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // extent reserve request
  logic ext_rq;
  assign ext_rq = cmd_valid && cmd_op == OP_RESERVE && cmd_extent;

  a_answer_lat: assert property (cmd_valid |=> rsp_valid) else $error("no answer");
  a_no_spurious: assert property (!cmd_valid |=> !rsp_valid) else $error("spurious answer");
  a_release_good: assert property (cmd_valid && cmd_op == OP_RELEASE |=> rsp_status == ST_GOOD)
    else $error("release not good");
  a_many_extents: assert property (ext_rq && cmd_list_len > EXT_LEN_ONE
    |=> rsp_status == ST_CHECK && rsp_code == ERR_ILL_BLOCK) else $error("long list not refused");
  a_rel_no_link: assert property (ext_rq && cmd_list_len == EXT_LEN_ONE && desc_rel_addr && !link_addr_valid
    |=> rsp_status == ST_CHECK && rsp_code == ERR_BAD_ARG) else $error("relative without link");
  a_empty_list: assert property (ext_rq && cmd_list_len == EXT_LEN_NONE |=> rsp_status == ST_GOOD)
    else $error("empty list not good");
  a_bdr_clears: assert property (bus_dev_reset ##1 !cmd_valid |-> ##1 unit_held == '0)
    else $error("bus reset kept units");
  a_sense_good: assert property (cmd_valid && cmd_op == OP_SENSE |=> rsp_status == ST_GOOD)
    else $error("sense not good");
  a_code_zero: assert property (cmd_valid && cmd_op != OP_SENSE ##1 rsp_status != ST_CHECK
    |-> rsp_code == 8'h00) else $error("stray code");

  c_conflict: cover property (rsp_valid && rsp_status == ST_CONFLICT);
  c_check: cover property (rsp_valid && rsp_status == ST_CHECK);
  c_held: cover property (unit_held != '0);
endmodule : rsv_mgr_asserts

bind rsv_mgr rsv_mgr_asserts #(.NREC(NREC)) rsv_mgr_asserts_inst (.clk(clk), .reset(reset),
  .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_extent(cmd_extent), .cmd_list_len(cmd_list_len),
  .desc_rel_addr(desc_rel_addr), .link_addr_valid(link_addr_valid), .bus_dev_reset(bus_dev_reset),
  .rsp_valid(rsp_valid), .rsp_status(rsp_status), .rsp_code(rsp_code), .unit_held(unit_held));

// *** dv/tb_top.sv ***
// Purpose: self-checking bench of the reservation manager
// Assumes: unit 0 of 256 blocks, link block 10h
// Notes: small record table of two entries
`timescale 1ns/1ns
module tb_top
  import rsv_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic bus_dev_reset = 1'b0;
  logic [LUN_W-1:0] lun_sel = '0;
  logic cmd_valid, cmd_extent, rsp_valid;
  rsv_op_e cmd_op;
  logic [ID_W-1:0] cmd_init;
  logic [7:0] cmd_res_id, rsp_status, rsp_code;
  logic [15:0] cmd_list_len;
  logic [1:0] desc_type, rel;
  logic [LBA_W-1:0] lba;
  logic [CNT_W-1:0] blocks;
  logic [NUM_LUN-1:0] unit_held;
  int err_total = 0;
  int checked = 0;

  // 50 MHz clock
  always #10 clk = ~clk;

  rsv_host rsv_host_inst (.clk(clk), .rsp_valid(rsp_valid), .rsp_status(rsp_status), .rsp_code(rsp_code),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_init(cmd_init), .cmd_extent(cmd_extent),
    .cmd_res_id(cmd_res_id), .cmd_list_len(cmd_list_len), .desc_type(desc_type), .rel(rel), .lba(lba),
    .blocks(blocks));

  rsv_mgr #(.NREC(2)) rsv_mgr_inst (.clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_init(cmd_init), .cmd_lun(lun_sel), .cmd_extent(cmd_extent), .cmd_res_id(cmd_res_id),
    .cmd_list_len(cmd_list_len), .cmd_lba(lba), .cmd_blocks(blocks), .desc_type(desc_type),
    .desc_rel_addr(rel[0]), .desc_blocks(blocks), .desc_lba(lba), .unit_blocks(32'h0000_0100),
    .link_addr_valid(rel[1]), .link_addr(32'h0000_0010), .bus_dev_reset(bus_dev_reset),
    .rsp_valid(rsp_valid), .rsp_status(rsp_status), .rsp_code(rsp_code), .unit_held(unit_held));

  task automatic fail(input string m);
    err_total++;
    $display("[FAIL] %0t %s", $time, m);
  endtask : fail

  // compare answer status and code
  task automatic cmp_rsp(input logic [7:0] es, input logic [7:0] ec);
    checked++;
    if (rsv_host_inst.st !== es || rsv_host_inst.cd !== ec) fail("answer mismatch");
  endtask : cmp_rsp

  // compare held-unit flags
  task automatic chk_held(input logic [7:0] e);
    @(posedge clk);
    #1;
    checked++;
    if (unit_held !== e) fail("held flags mismatch");
  endtask : chk_held

  task automatic res(input int ini, input int ext, input int id, input int len, input int ty, input int r,
    input int a, input int n, input logic [7:0] es, input logic [7:0] ec);
    rsv_host_inst.send(OP_RESERVE, ini, ext, id, len, ty, r, a, n);
    cmp_rsp(es, ec);
  endtask : res

  task automatic acc(input rsv_op_e op, input int ini, input int ext, input int id, input int a,
    input logic [7:0] es, input logic [7:0] ec);
    rsv_host_inst.send(op, ini, ext, id, 8, 0, 0, a, 1);
    cmp_rsp(es, ec);
  endtask : acc

  task automatic bdr;
    @(posedge clk);
    bus_dev_reset <= 1'b1;
    @(posedge clk);
    bus_dev_reset <= 1'b0;
  endtask : bdr

  task automatic t_whole;
    res(1, 0, 0, 0, 0, 0, 0, 0, ST_GOOD, 8'h00);
    chk_held(8'h01);
    // second unit reserved alongside the first, records kept per unit
    @(posedge clk);
    lun_sel <= 3'h1;
    res(2, 0, 0, 0, 0, 0, 0, 0, ST_GOOD, 8'h00);
    chk_held(8'h03);
    acc(OP_RELEASE, 2, 0, 0, 0, ST_GOOD, 8'h00);
    @(posedge clk);
    lun_sel <= 3'h0;
    res(1, 0, 8'h5a, 16'h1234, 3, 0, 0, 0, ST_GOOD, 8'h00);
    acc(OP_READ, 2, 0, 0, 5, ST_CONFLICT, 8'h00);
    acc(OP_WRITE, 2, 0, 0, 5, ST_CONFLICT, 8'h00);
    acc(OP_SENSE, 2, 0, 0, 0, ST_GOOD, ERR_NO_SENSE);
    res(2, 0, 0, 0, 0, 0, 0, 0, ST_CONFLICT, 8'h00);
    res(2, 1, 4, 8, 3, 0, 16, 1, ST_CHECK, ERR_ILL_REQ);
    acc(OP_READ, 1, 0, 0, 5, ST_GOOD, 8'h00);
    acc(OP_RELEASE, 1, 0, 0, 0, ST_GOOD, 8'h00);
    chk_held(8'h00);
    $display("test whole done");
  endtask : t_whole

  task automatic t_errs;
    res(1, 1, 1, 16, 3, 0, 16, 1, ST_CHECK, ERR_ILL_BLOCK);
    res(1, 1, 1, 4, 3, 0, 16, 1, ST_CHECK, ERR_BAD_ARG);
    res(1, 1, 1, 0, 3, 0, 16, 1, ST_GOOD, 8'h00);
    res(1, 1, 1, 8, 3, 1, 16, 1, ST_CHECK, ERR_BAD_ARG);
    res(1, 1, 1, 8, 3, 0, 256, 1, ST_CHECK, ERR_ILL_BLOCK);
    acc(OP_SENSE, 1, 0, 0, 0, ST_GOOD, ERR_ILL_BLOCK);
    chk_held(8'h00);
    $display("test errors done");
  endtask : t_errs

  task automatic t_misc;
    res(1, 1, 1, 8, 3, 0, 16, 16, ST_GOOD, 8'h00);
    // two-block read straddling the extent start, partly reserved
    rsv_host_inst.send(OP_READ, 2, 0, 0, 8, 0, 0, 15, 2);
    cmp_rsp(ST_CONFLICT, 8'h00);
    acc(OP_READ, 2, 0, 0, 8, ST_GOOD, 8'h00);
    acc(OP_FORMAT, 2, 0, 0, 0, ST_CONFLICT, 8'h00);
    res(3, 0, 0, 0, 0, 0, 0, 0, ST_CONFLICT, 8'h00);
    res(2, 1, 5, 8, 3, 0, 128, 0, ST_GOOD, 8'h00);
    acc(OP_WRITE, 3, 0, 0, 255, ST_CONFLICT, 8'h00);
    acc(OP_RELEASE, 1, 1, 9, 0, ST_GOOD, 8'h00);
    acc(OP_READ, 3, 0, 0, 16, ST_CONFLICT, 8'h00);
    acc(OP_RELEASE, 1, 1, 1, 0, ST_GOOD, 8'h00);
    acc(OP_READ, 3, 0, 0, 16, ST_GOOD, 8'h00);
    res(3, 1, 7, 8, 3, 3, 32, 1, ST_GOOD, 8'h00);
    acc(OP_READ, 4, 0, 0, 48, ST_CONFLICT, 8'h00);
    bdr;
    chk_held(8'h00);
    // hard reset mid-run drops a whole-unit reservation
    res(1, 0, 0, 0, 0, 0, 0, 0, ST_GOOD, 8'h00);
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    chk_held(8'h00);
    $display("test extents done");
  endtask : t_misc

  task automatic t_types;
    logic [15:0] mask;
    int a;
    int b;
    mask = 16'hfdbe;
    for (a = 0; a < 4; a++) begin
      for (b = 0; b < 4; b++) begin
        res(1, 1, 1, 8, a, 0, 16, 16, ST_GOOD, 8'h00);
        acc(OP_READ, 2, 0, 0, 31, (a >= 2) ? ST_CONFLICT : ST_GOOD, 8'h00);
        acc(OP_WRITE, 2, 0, 0, 31, (a != 2) ? ST_CONFLICT : ST_GOOD, 8'h00);
        acc(OP_WRITE, 1, 0, 0, 16, (a == 0) ? ST_CONFLICT : ST_GOOD, 8'h00);
        res(2, 1, 2, 8, b, 0, 24, 4, mask[a*4+b] ? ST_CONFLICT : ST_GOOD, 8'h00);
        bdr;
      end
    end
    $display("test types done");
  endtask : t_types

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_whole();
    t_errs();
    t_misc();
    t_types();
    close_out();
  end

  // watchdog
  initial begin
    #200000;
    fail("watchdog expired");
    close_out();
  end
endmodule : tb_top
